// File: include/seq_pkg.sv
package seq_pkg;
    localparam int CLK_NS = 40;
    localparam int OSC_START_NS = 5000;
    // Longest time: rounds down
    localparam int OSC_START_CYC = OSC_START_NS / CLK_NS;

    localparam logic [7:0] A_ONE = 8'h00;
    localparam logic [7:0] A_TWO = 8'h04;
    localparam logic [7:0] A_CFG = 8'h08;
    localparam logic [7:0] A_CVH = 8'h0c;
    localparam logic [7:0] A_CVL = 8'h10;
    localparam logic [7:0] A_RH = 8'h14;
    localparam logic [7:0] A_RL = 8'h18;

    typedef enum logic [2:0] {
        R_ONE, R_TWO, R_CFG, R_CVH, R_CVL, R_RH, R_RL, R_NONE
    } reg_sel_t;

    localparam int B_DONE = 7;
    localparam int B_IRQ = 6;
    localparam int B_CONT = 5;
    localparam int B_ACT = 7;
    localparam int B_TRIG = 6;
    localparam int B_CMPEN = 5;
    localparam int B_CMPGT = 4;
    localparam int B_LSMP = 4;
    localparam int F_DIV = 5;
    localparam int F_MODE = 2;
    localparam int F_ICLK = 0;

    localparam logic [4:0] CHAN_OFF = 5'h1f;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [1:0] CK_BUS = 2'h0;
    localparam logic [1:0] CK_HALF = 2'h1;
    localparam logic [1:0] CK_ALT = 2'h2;
    localparam logic [1:0] CK_OSC = 2'h3;
    localparam logic [7:0] SMP_SHORT = 8'h08;
    localparam logic [7:0] SMP_LONG = 8'h1c;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_10 = 4'ha;
    localparam logic [3:0] LOW_SHIFT = 4'h2;
    localparam logic [9:0] SAR_MSB = 10'h200;
    localparam logic [1:0] OKAY = 2'h0;
    localparam logic [1:0] SLVERR = 2'h2;

    typedef enum logic [1:0] {
        S_IDLE, S_START, S_SAMPLE, S_CONV
    } conv_state_t;
endpackage : seq_pkg

// File: rtl/adc_conversion_sequencer.sv
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic hw_trigger_input,
    input wire logic alternate_clock,
    input wire logic async_conv_clock,
    input wire logic stop_mode,
    input wire logic comparator_high,
    output logic sample_enable,
    output logic [9:0] dac_code,
    output logic async_osc_enable,
    output logic converter_active,
    output logic done_irq
);
    typedef struct packed {
        logic aw_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic w_hold;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic irq_en;
        logic cont;
        logic [4:0] chan;
        logic trig_sel;
        logic cmp_en;
        logic cmp_gt;
        logic [7:0] cfg;
        logic [1:0] cv_hi;
        logic [7:0] cv_lo;
        logic [1:0] res_hi;
        logic [7:0] res_lo;
        logic done;
        logic hi_pend;
        logic [2:0] trig_s;
        logic [2:0] alt_s;
        logic [2:0] osc_s;
        logic bus_half;
        logic [2:0] div_cnt;
        seq_pkg::conv_state_t fsm;
        logic [7:0] cnt;
        logic [3:0] bit_idx;
        logic [9:0] sar;
    } state_t;

    state_t q, d;

    function automatic seq_pkg::reg_sel_t decode(
        input logic [ADDR_W-1:0] a
    );
        case (a)
            ADDR_W'(seq_pkg::A_ONE): decode = seq_pkg::R_ONE;
            ADDR_W'(seq_pkg::A_TWO): decode = seq_pkg::R_TWO;
            ADDR_W'(seq_pkg::A_CFG): decode = seq_pkg::R_CFG;
            ADDR_W'(seq_pkg::A_CVH): decode = seq_pkg::R_CVH;
            ADDR_W'(seq_pkg::A_CVL): decode = seq_pkg::R_CVL;
            ADDR_W'(seq_pkg::A_RH): decode = seq_pkg::R_RH;
            ADDR_W'(seq_pkg::A_RL): decode = seq_pkg::R_RL;
            default: decode = seq_pkg::R_NONE;
        endcase
    endfunction : decode

    seq_pkg::reg_sel_t wr_sel, rd_sel;
    logic wr_en, wr_one, sw_start, hw_start, cfg_abort;
    logic stop_abort, trig_rise, converter_clock, src_tick, mode10;
    logic finish, blocked, cond, xfer, launch;
    logic [1:0] icl;
    logic [2:0] div_lim;
    logic [3:0] pos, nbits;
    logic [7:0] smp;
    logic [9:0] sar_nx, res, cv, store;
    logic [10:0] diff;

    assign awready = ce && !q.aw_hold && !q.bvalid;
    assign wready = ce && !q.w_hold && !q.bvalid;
    assign arready = ce && !q.rvalid;

    always_comb begin
        d = q;
        icl = q.cfg[seq_pkg::F_ICLK +: 2];
        mode10 = q.cfg[seq_pkg::F_MODE +: 2] == seq_pkg::MODE_10;
        nbits = mode10 ? seq_pkg::BITS_10 : seq_pkg::BITS_8;
        smp = q.cfg[seq_pkg::B_LSMP] ? seq_pkg::SMP_LONG
                                     : seq_pkg::SMP_SHORT;
        // AXI write: address and data latched in either order
        if (awvalid && awready) begin
            d.aw_hold = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            d.w_hold = 1'b1;
            d.w_data = wdata[7:0];
            d.w_lane0 = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        wr_sel = decode(q.aw_addr);
        wr_en = q.aw_hold && q.w_hold && q.w_lane0;
        if (q.aw_hold && q.w_hold) begin
            d.aw_hold = 1'b0;
            d.w_hold = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = (wr_sel == seq_pkg::R_NONE) ? seq_pkg::SLVERR
                                                  : seq_pkg::OKAY;
        end
        wr_one = wr_en && wr_sel == seq_pkg::R_ONE;
        cfg_abort = wr_en && (wr_sel == seq_pkg::R_TWO ||
            wr_sel == seq_pkg::R_CFG || wr_sel == seq_pkg::R_CVH ||
            wr_sel == seq_pkg::R_CVL);
        sw_start = wr_one && !q.trig_sel &&
            q.w_data[4:0] != seq_pkg::CHAN_OFF;
        if (wr_en) begin
            case (wr_sel)
                seq_pkg::R_ONE: begin
                    d.irq_en = q.w_data[seq_pkg::B_IRQ];
                    d.cont = q.w_data[seq_pkg::B_CONT];
                    d.chan = q.w_data[4:0];
                    d.done = 1'b0;
                end
                seq_pkg::R_TWO: begin
                    d.trig_sel = q.w_data[seq_pkg::B_TRIG];
                    d.cmp_en = q.w_data[seq_pkg::B_CMPEN];
                    d.cmp_gt = q.w_data[seq_pkg::B_CMPGT];
                end
                seq_pkg::R_CFG: d.cfg = q.w_data;
                seq_pkg::R_CVH: d.cv_hi = q.w_data[1:0];
                seq_pkg::R_CVL: d.cv_lo = q.w_data;
                default: ;
            endcase
        end
        // AXI read with its side effects on the result pair
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        rd_sel = decode(araddr);
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rresp = seq_pkg::OKAY;
            case (rd_sel)
                seq_pkg::R_ONE: d.rdata = {q.done, q.irq_en,
                                           q.cont, q.chan};
                seq_pkg::R_TWO: d.rdata = {q.fsm != seq_pkg::S_IDLE,
                    q.trig_sel, q.cmp_en, q.cmp_gt, 4'h0};
                seq_pkg::R_CFG: d.rdata = q.cfg;
                seq_pkg::R_CVH: d.rdata = {6'h00, q.cv_hi};
                seq_pkg::R_CVL: d.rdata = q.cv_lo;
                seq_pkg::R_RH: begin
                    d.rdata = {6'h00, q.res_hi};
                    d.hi_pend = mode10;
                end
                seq_pkg::R_RL: begin
                    d.rdata = q.res_lo;
                    d.hi_pend = 1'b0;
                    d.done = 1'b0;
                end
                default: begin
                    d.rdata = 8'h00;
                    d.rresp = seq_pkg::SLVERR;
                end
            endcase
        end
        // Two-flop synchronisers, third stage for edge detection
        d.trig_s = {q.trig_s[1:0], hw_trigger_input};
        d.alt_s = {q.alt_s[1:0], alternate_clock};
        d.osc_s = {q.osc_s[1:0], async_conv_clock};
        trig_rise = q.trig_s[1] && !q.trig_s[2];
        // Converter clock: selected source, then divider
        d.bus_half = !q.bus_half;
        case (icl)
            seq_pkg::CK_BUS: src_tick = 1'b1;
            seq_pkg::CK_HALF: src_tick = q.bus_half;
            seq_pkg::CK_ALT: src_tick = q.alt_s[1] && !q.alt_s[2];
            default: src_tick = q.osc_s[1] && !q.osc_s[2];
        endcase
        case (q.cfg[seq_pkg::F_DIV +: 2])
            2'h0: div_lim = 3'h0;
            2'h1: div_lim = 3'h1;
            2'h2: div_lim = 3'h3;
            default: div_lim = 3'h7;
        endcase
        converter_clock = 1'b0;
        if (src_tick && (q.fsm == seq_pkg::S_SAMPLE ||
                         q.fsm == seq_pkg::S_CONV)) begin
            if (q.div_cnt == div_lim) begin
                converter_clock = 1'b1;
                d.div_cnt = 3'h0;
            end else begin
                d.div_cnt = q.div_cnt + 3'h1;
            end
        end
        // Approximation step and result arithmetic
        pos = mode10 ? q.bit_idx : q.bit_idx + seq_pkg::LOW_SHIFT;
        sar_nx = q.sar;
        if (!comparator_high) begin
            sar_nx[pos] = 1'b0;
        end
        if (q.bit_idx != 4'h0) begin
            sar_nx[pos - 4'h1] = 1'b1;
        end
        res = mode10 ? sar_nx : {2'h0, sar_nx[9:2]};
        cv = mode10 ? {q.cv_hi, q.cv_lo} : {2'h0, q.cv_lo};
        diff = {1'b0, res} + {1'b0, ~cv} + 11'h001;
        cond = q.cmp_gt ? (res >= cv) : (res < cv);
        store = q.cmp_en ? diff[9:0] : res;
        blocked = mode10 && q.hi_pend;
        finish = 1'b0;
        xfer = 1'b0;
        case (q.fsm)
            seq_pkg::S_IDLE: ;
            seq_pkg::S_START: begin
                // Oscillator settling allowance before sampling
                if (q.cnt == 8'(seq_pkg::OSC_START_CYC - 1)) begin
                    d.fsm = seq_pkg::S_SAMPLE;
                    d.cnt = 8'h00;
                end else begin
                    d.cnt = q.cnt + 8'h01;
                end
            end
            seq_pkg::S_SAMPLE: begin
                if (converter_clock) begin
                    if (q.cnt == smp - 8'h01) begin
                        d.fsm = seq_pkg::S_CONV;
                        d.cnt = 8'h00;
                        d.bit_idx = nbits - 4'h1;
                        d.sar = seq_pkg::SAR_MSB;
                    end else begin
                        d.cnt = q.cnt + 8'h01;
                    end
                end
            end
            seq_pkg::S_CONV: begin
                if (converter_clock) begin
                    d.sar = sar_nx;
                    d.bit_idx = q.bit_idx - 4'h1;
                    finish = q.bit_idx == 4'h0;
                end
            end
            default: d.fsm = seq_pkg::S_IDLE;
        endcase
        if (finish) begin
            d.fsm = q.cont ? seq_pkg::S_SAMPLE
                           : seq_pkg::S_IDLE;
            d.cnt = 8'h00;
            d.div_cnt = 3'h0;
            if (blocked) begin
                // Result discarded; retry unless single false compare
                if (!q.cont && q.cmp_en && !cond) begin
                    d.fsm = seq_pkg::S_IDLE;
                end else begin
                    d.fsm = seq_pkg::S_SAMPLE;
                end
            end else if (!q.cmp_en || cond) begin
                xfer = 1'b1;
                d.res_hi = mode10 ? store[9:8] : 2'h0;
                d.res_lo = store[7:0];
                // Set after the clears above, so a set wins
                d.done = 1'b1;
            end
        end
        // Only idle edges count; continuous runs never see idle
        hw_start = trig_rise && q.trig_sel &&
            q.fsm == seq_pkg::S_IDLE &&
            q.chan != seq_pkg::CHAN_OFF;
        stop_abort = stop_mode && icl != seq_pkg::CK_OSC;
        launch = sw_start || hw_start;
        if (launch) begin
            d.fsm = (q.fsm == seq_pkg::S_IDLE &&
                icl == seq_pkg::CK_OSC) ? seq_pkg::S_START
                                        : seq_pkg::S_SAMPLE;
            d.cnt = 8'h00;
            d.div_cnt = 3'h0;
        end else if (wr_one || cfg_abort) begin
            d.fsm = seq_pkg::S_IDLE;
        end
        if (stop_abort) begin
            d.fsm = seq_pkg::S_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.chan <= seq_pkg::CHAN_OFF;
            q.cfg <= seq_pkg::CFG_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rdata = {24'h000000, q.rdata};
    assign rresp = q.rresp;
    assign sample_enable = q.fsm == seq_pkg::S_SAMPLE;
    assign dac_code = q.sar;
    assign converter_active = q.fsm != seq_pkg::S_IDLE;
    // Oscillator only runs while it is needed
    assign async_osc_enable = converter_active &&
        q.cfg[seq_pkg::F_ICLK +: 2] == seq_pkg::CK_OSC;
    assign done_irq = q.done && q.irq_en;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_sw_start: assert property (
        ce && sw_start && !stop_abort |=>
        q.fsm inside {seq_pkg::S_SAMPLE, seq_pkg::S_START})
        else $error("software start did not begin conversion");
    chk_hw_start: assert property (
        ce && hw_start && !wr_en && !stop_abort |=>
        q.fsm != seq_pkg::S_IDLE)
        else $error("trigger edge did not begin conversion");
    chk_hw_busy: assert property (
        ce && q.fsm == seq_pkg::S_CONV && trig_rise && !finish &&
        !wr_en && !stop_abort |=> q.fsm == seq_pkg::S_CONV)
        else $error("trigger edge disturbed a conversion");
    chk_cont_next: assert property (
        ce && xfer && q.cont && !wr_en && !stop_abort |=>
        q.fsm == seq_pkg::S_SAMPLE && q.cnt == 8'h00)
        else $error("continuous mode did not restart");
    chk_done_xfer: assert property (
        ce && xfer |=> q.done && q.res_lo == $past(store[7:0]))
        else $error("transfer did not store result and flag");
    chk_cmp_store: assert property (
        ce && xfer && q.cmp_en && mode10 |=>
        {q.res_hi, q.res_lo} == $past(diff[9:0]))
        else $error("compare difference not stored");
    chk_block_keep: assert property (
        ce && finish && blocked |=>
        $stable({q.res_hi, q.res_lo}) && !$rose(q.done))
        else $error("blocked result was transferred");
    chk_block_again: assert property (
        ce && finish && blocked && (q.cont || !q.cmp_en || cond) &&
        !wr_en && !stop_abort |=> q.fsm == seq_pkg::S_SAMPLE)
        else $error("blocked transfer did not restart");
    chk_cmp_false: assert property (
        ce && finish && q.cmp_en && !cond |=>
        $stable(q.res_lo) && !$rose(q.done))
        else $error("false compare changed results");
    chk_cfg_abort: assert property (
        ce && cfg_abort |=> q.fsm == seq_pkg::S_IDLE)
        else $error("configuration write did not abort");
    chk_stop_abort: assert property (
        ce && stop_abort |=> q.fsm == seq_pkg::S_IDLE ##1
        q.fsm == seq_pkg::S_IDLE || !stop_abort)
        else $error("stop did not abort conversion");
    chk_abort_keep: assert property (
        ce && (cfg_abort || stop_abort) && !finish |=>
        $stable({q.res_hi, q.res_lo}))
        else $error("abort altered results");
    chk_off_idle: assert property (
        q.chan == seq_pkg::CHAN_OFF |->
        q.fsm == seq_pkg::S_IDLE && !async_osc_enable)
        else $error("disabled channel but converter active");
endmodule : adc_conversion_sequencer
`default_nettype wire

// File: test/analog_channel.sv
`timescale 1ns/1ps
`default_nettype none
// Ideal input channel: the held level is compared with the trial code
module analog_channel (
    input wire logic [9:0] level,
    input wire logic [9:0] dac_code,
    output logic comparator_high
);
    // Driven from bus-clock levels, so it is settled at every converter tick
    assign comparator_high = (level >= dac_code);
endmodule : analog_channel
`default_nettype wire

// File: test/adc_conversion_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, comparator_high;
    logic sample_enable, async_osc_enable, converter_active, done_irq;
    logic hw_trig, stop_mode;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    logic [9:0] dac_code, level;
    logic [2:0] ck_cnt;
    int bad_count, tests_run;

    adc_conversion_sequencer uut (.aclk(aclk), .aresetn(aresetn),
        .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hw_trigger_input(hw_trig), .alternate_clock(ck_cnt[2]),
        .async_conv_clock(ck_cnt[1]), .stop_mode(stop_mode),
        .comparator_high(comparator_high), .sample_enable(sample_enable),
        .dac_code(dac_code), .async_osc_enable(async_osc_enable),
        .converter_active(converter_active), .done_irq(done_irq));

    analog_channel far_end (.level(level), .dac_code(dac_code),
        .comparator_high(comparator_high));

    // Slow source clocks, so the oscillator path sees real edges
    always @(posedge aclk) begin
        if (!aresetn) begin
            ck_cnt <= 3'h0;
        end else begin
            ck_cnt <= ck_cnt + 3'h1;
        end
    end

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: data %h, expected %h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: resp %h, expected %h", $time, got, exp);
        end
    endtask : chk_resp

    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1 || n > 100) break;
        end
        bready <= 1'b0;
        chk_resp(bresp, er);
    endtask : axi_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1 || n > 100) break;
        end
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
        chk_data(rd, {24'h000000, exp});
        chk_resp(rr, er);
    endtask : rd_chk

    task automatic wait_done(input int lo, input int hi);
        int n;
        n = 0;
        while (done_irq !== 1'b1 && n <= hi) begin
            @(posedge aclk);
            n++;
        end
        chk_flag(n >= lo && n <= hi, 1'b1);
    endtask : wait_done

    // Neither a done flag nor, if asked, any activity for n cycles
    task automatic quiet(input int n, input logic act);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge aclk);
            if (done_irq !== 1'b0) seen = 1'b1;
            if (act && converter_active !== 1'b0) seen = 1'b1;
        end
        chk_flag(seen, 1'b0);
    endtask : quiet

    task automatic finish_test();
        $display("%0d comparisons, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {hw_trig, stop_mode, awaddr, araddr, wstrb} = 22'h000000;
        {wdata, level, bad_count, tests_run} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(seq_pkg::A_ONE, 8'h1f, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_RL, 8'h00, seq_pkg::OKAY);
        rd_chk(8'h1c, 8'h00, seq_pkg::SLVERR);
        $display("reset test ended");
        level <= 10'h2a5;
        axi_wr(seq_pkg::A_CFG, 8'h08, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        chk_flag(sample_enable, 1'b1);
        axi_wr(8'h1c, 8'h55, seq_pkg::SLVERR);
        wait_done(1, 28);
        chk_data({22'h000000, dac_code}, 32'h000002a5);
        rd_chk(seq_pkg::A_RH, 8'h02, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_RL, 8'ha5, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        chk_flag(done_irq, 1'b0);
        $display("single test ended");
        level <= 10'h3c3;
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_TWO, 8'h00, seq_pkg::OKAY);
        quiet(40, 1'b1);
        rd_chk(seq_pkg::A_RL, 8'ha5, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        stop_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        chk_flag(converter_active, 1'b0);
        stop_mode <= 1'b0;
        quiet(40, 1'b1);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        repeat (6) @(posedge aclk);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        wait_done(15, 28);
        rd_chk(seq_pkg::A_RH, 8'h03, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_RL, 8'hc3, seq_pkg::OKAY);
        $display("abort test ended");
        for (int d = 0; d < 4; d++) begin
            axi_wr(seq_pkg::A_CFG, {1'b0, d[1:0], 5'h08}, seq_pkg::OKAY);
            axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
            wait_done((17 << d) - 2, (23 << d) + 8);
            rd_chk(seq_pkg::A_RL, 8'hc3, seq_pkg::OKAY);
        end
        $display("divider test ended");
        axi_wr(seq_pkg::A_CFG, 8'h08, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_CVH, 8'h01, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_CVL, 8'h00, seq_pkg::OKAY);
        level <= 10'h2a5;
        axi_wr(seq_pkg::A_TWO, 8'h30, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        wait_done(1, 28);
        rd_chk(seq_pkg::A_RH, 8'h01, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_RL, 8'ha5, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_TWO, 8'h20, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        quiet(40, 1'b0);
        rd_chk(seq_pkg::A_RL, 8'ha5, seq_pkg::OKAY);
        level <= 10'h0f0;
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        wait_done(1, 28);
        rd_chk(seq_pkg::A_RH, 8'h03, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_RL, 8'hf0, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_TWO, 8'h00, seq_pkg::OKAY);
        $display("compare test ended");
        // A high-byte read left pending on purpose, against normal usage
        level <= 10'h155;
        rd_chk(seq_pkg::A_RH, 8'h03, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        repeat (60) @(posedge aclk);
        chk_flag(converter_active, 1'b1);
        chk_flag(done_irq, 1'b0);
        rd_chk(seq_pkg::A_RL, 8'hf0, seq_pkg::OKAY);
        wait_done(1, 28);
        rd_chk(seq_pkg::A_RH, 8'h01, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_RL, 8'h55, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h61, seq_pkg::OKAY);
        wait_done(1, 28);
        level <= 10'h0aa;
        rd_chk(seq_pkg::A_RL, 8'h55, seq_pkg::OKAY);
        wait_done(1, 20);
        rd_chk(seq_pkg::A_RL, 8'haa, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h5f, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_RL, 8'haa, seq_pkg::OKAY);
        quiet(40, 1'b1);
        $display("block test ended");
        axi_wr(seq_pkg::A_TWO, 8'h40, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        quiet(30, 1'b1);
        hw_trig <= 1'b1;
        wait_done(1, 32);
        rd_chk(seq_pkg::A_RL, 8'haa, seq_pkg::OKAY);
        quiet(30, 1'b1);
        hw_trig <= 1'b0;
        axi_wr(seq_pkg::A_TWO, 8'h00, seq_pkg::OKAY);
        $display("trigger test ended");
        axi_wr(seq_pkg::A_CFG, 8'h0b, seq_pkg::OKAY);
        chk_flag(async_osc_enable, 1'b0);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        stop_mode <= 1'b1;
        chk_flag(async_osc_enable, 1'b1);
        wait_done(1, 240);
        @(posedge aclk);
        chk_flag(async_osc_enable, 1'b0);
        stop_mode <= 1'b0;
        rd_chk(seq_pkg::A_RL, 8'haa, seq_pkg::OKAY);
        $display("oscillator test ended");
        axi_wr(seq_pkg::A_CFG, 8'h08, seq_pkg::OKAY);
        axi_wr(seq_pkg::A_ONE, 8'h41, seq_pkg::OKAY);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk_flag(converter_active, 1'b0);
        chk_data({22'h000000, dac_code}, 32'h00000000);
        rd_chk(seq_pkg::A_RL, 8'h00, seq_pkg::OKAY);
        rd_chk(seq_pkg::A_ONE, 8'h1f, seq_pkg::OKAY);
        $display("second reset test ended");
        finish_test();
    end
endmodule : adc_conversion_sequencer_test
`default_nettype wire
